// >>> fpi_pkg.sv
// Purpose: shared constants and types for the front-panel indicator block
// Assumes: 50 MHz system clock
// Notes:   times are kept in their own unit; cycle counts derive from them
package fpi_pkg;

  localparam int unsigned FPI_CLK_HZ      = 50_000_000;
  localparam int unsigned FPI_CLK_KHZ     = FPI_CLK_HZ / 1000;
  // long-press threshold, seconds
  localparam int unsigned FPI_HOLD_S      = 5;
  localparam int unsigned FPI_HOLD_CYC    = FPI_HOLD_S * FPI_CLK_HZ;
  // button debounce time, ms
  localparam int unsigned FPI_DEB_MS      = 10;
  localparam int unsigned FPI_DEB_CYC     = FPI_DEB_MS * FPI_CLK_KHZ;
  // one millisecond tick
  localparam int unsigned FPI_TICK_CYC    = FPI_CLK_KHZ;
  // activity blink half period, ms
  localparam int unsigned FPI_ACT_MS      = 50;
  // corrupt-image blink pattern
  localparam int unsigned FPI_BLINKS      = 3;

  // register byte offsets
  localparam logic [7:0] FPI_CTRL_OFS     = 8'h00;
  localparam logic [7:0] FPI_BON_OFS      = 8'h04;
  localparam logic [7:0] FPI_BOFF_OFS     = 8'h08;
  localparam logic [7:0] FPI_BGAP_OFS     = 8'h0C;
  localparam logic [7:0] FPI_STAT_OFS     = 8'h10;
  localparam logic [7:0] FPI_ISTAT_OFS    = 8'h14;
  localparam logic [7:0] FPI_IEN_OFS      = 8'h18;
  localparam logic [7:0] FPI_ICLR_OFS     = 8'h1C;

  // control fields and reset values
  localparam int unsigned FPI_CTRL_MDIX   = 0;
  localparam int unsigned FPI_CTRL_ACTBL  = 1;
  localparam logic [1:0]  FPI_CTRL_RST    = 2'h3;
  localparam logic [15:0] FPI_BON_RST     = 16'h00FA;
  localparam logic [15:0] FPI_BOFF_RST    = 16'h00FA;
  localparam logic [15:0] FPI_BGAP_RST    = 16'h03E8;

  // interrupt bits
  localparam int unsigned FPI_EV_REBOOT   = 0;
  localparam int unsigned FPI_EV_FACTORY  = 1;
  localparam int unsigned FPI_EV_CORRUPT  = 2;
  localparam int unsigned FPI_EV_LINK     = 3;
  localparam int unsigned FPI_NEV         = 4;

  // phy speed codes
  localparam logic [1:0]  FPI_SPD_10      = 2'h0;
  localparam logic [1:0]  FPI_SPD_100     = 2'h1;
  localparam logic [1:0]  FPI_SPD_1000    = 2'h2;

  typedef enum logic [1:0] {
    FPI_BT_IDLE,
    FPI_BT_PRESS,
    FPI_BT_LONG
  } fpi_btn_st_t;

  typedef struct packed {
    logic       link_up;
    logic [1:0] speed;
    logic       activity;
  } fpi_phy_t;

  typedef struct packed {
    logic power;
    logic active;
    logic status;
    logic spd_yellow;
    logic spd_green;
    logic link_activity_lamp;
  } fpi_lamps_t;

  typedef struct packed {
    logic        ip_dynamic;
    logic        comment_empty;
    logic        admin_nopass;
    logic [31:0] host_serial;
  } fpi_cfg_t;

endpackage : fpi_pkg

// >>> fpi_debounce.sv
// Purpose: debounce of the reset pushbutton level
// Assumes: input already synchronous to hclk
// Notes:   output changes only after the input held steady for CYC cycles
`timescale 1ns/1ps
module fpi_debounce
  import fpi_pkg::*;
#(
  parameter int unsigned CYC = FPI_DEB_CYC
) (
  input  wire logic hclk,    // system clock
  input  wire logic hresetn, // async reset, active low
  input  wire logic raw,     // bouncy level
  output logic      clean    // filtered level
);

  logic [31:0] cnt_q;

  // restart the count whenever the input agrees with the output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 32'h0;
      clean <= 1'b0;
    end else if (raw == clean) begin
      cnt_q <= 32'h0;
    end else if (cnt_q >= CYC - 1) begin
      cnt_q <= 32'h0;
      clean <= raw;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

endmodule : fpi_debounce

// >>> fpi_blink.sv
// Purpose: repeating three-blink pattern for the corrupt-image indication
// Assumes: tick is a one-cycle pulse every millisecond
// Notes:   on, off and gap are in ms; zero is treated as one tick
`timescale 1ns/1ps
module fpi_blink
  import fpi_pkg::*;
(
  input  wire logic        hclk,    // system clock
  input  wire logic        hresetn, // async reset, active low
  input  wire logic        en,      // run the pattern
  input  wire logic        tick,    // 1 ms pulse
  input  wire logic [15:0] on_ms,   // lamp-on time
  input  wire logic [15:0] off_ms,  // between blinks
  input  wire logic [15:0] gap_ms,  // after the third blink
  output logic             lamp     // pattern output
);

  typedef enum logic [1:0] {FPI_BL_ON, FPI_BL_OFF, FPI_BL_GAP} fpi_bl_st_t;

  fpi_bl_st_t  st_q;
  logic [15:0] ms_q;
  logic [1:0]  n_q;
  logic [15:0] lim;

  always_comb begin
    case (st_q)
      FPI_BL_ON:  lim = on_ms;
      FPI_BL_OFF: lim = off_ms;
      default:    lim = gap_ms;
    endcase
  end

  // blink sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= FPI_BL_ON;
      ms_q <= 16'h0;
      n_q  <= 2'h0;
    end else if (!en) begin
      st_q <= FPI_BL_ON;
      ms_q <= 16'h0;
      n_q  <= 2'h0;
    end else if (tick) begin
      if (ms_q + 16'h1 < lim) begin
        ms_q <= ms_q + 16'h1;
      end else begin
        ms_q <= 16'h0;
        case (st_q)
          FPI_BL_ON: begin
            n_q  <= n_q + 2'h1;
            st_q <= (n_q == 2'(FPI_BLINKS - 1)) ? FPI_BL_GAP : FPI_BL_OFF;
          end
          FPI_BL_OFF: st_q <= FPI_BL_ON;
          default: begin
            n_q  <= 2'h0;
            st_q <= FPI_BL_ON;
          end
        endcase
      end
    end
  end

  assign lamp = en && (st_q == FPI_BL_ON);

endmodule : fpi_blink

// >>> fpi_top.sv
// Purpose: front-panel lamps and reset-button timing with an AHB-Lite register file
// Assumes: all inputs synchronous to hclk; single word AHB transfers
// Notes:   lamps are registered, so each follows its cause one cycle later
`timescale 1ns/1ps
module fpi_top
  import fpi_pkg::*;
#(
  parameter int unsigned HOLD_CYC = FPI_HOLD_CYC, // long-press cycles
  parameter int unsigned DEB_CYC  = FPI_DEB_CYC,  // debounce cycles
  parameter int unsigned TICK_CYC = FPI_TICK_CYC  // cycles per ms
) (
  input  wire logic        hclk,          // system clock
  input  wire logic        hresetn,       // async reset, active low
  input  wire logic        hsel,          // slave select
  input  wire logic [31:0] haddr,         // byte address
  input  wire logic [1:0]  htrans,        // transfer type
  input  wire logic        hwrite,        // write when high
  input  wire logic [2:0]  hsize,         // word only
  input  wire logic [31:0] hwdata,        // write data
  input  wire logic        hready,        // bus ready
  output logic             hreadyout,     // always ready
  output logic             hresp,         // always okay
  output logic [31:0]      hrdata,        // read data
  input  wire logic        power_ok,      // chassis power good
  input  wire logic        task_run,      // acquisition task active
  input  wire logic        fw_busy,       // boot, update or restore
  input  wire logic        fw_corrupt,    // image check failed
  input  wire fpi_phy_t    phy,           // phy link state
  input  wire logic        button_n,      // pushbutton, low when pressed
  input  wire logic [31:0] serial_num,    // chassis serial number
  output fpi_lamps_t       lamps,         // front-panel lamps
  output logic             mdix_auto,     // phy auto crossover enable
  output logic             reboot_req,    // one-cycle reboot pulse
  output logic             factory_req,   // one-cycle factory restore pulse
  output fpi_cfg_t         cfg_default,   // restored configuration
  output logic             irq            // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic                 wr_pend_q;
  logic [7:0]           wa_q;
  logic [1:0]           ctrl_q;
  logic [15:0]          bon_q;
  logic [15:0]          boff_q;
  logic [15:0]          bgap_q;
  logic [FPI_NEV-1:0]   ist_q;
  logic [FPI_NEV-1:0]   ien_q;
  logic [FPI_NEV-1:0]   ev;
  logic [FPI_NEV-1:0]   clr;
  logic [31:0]          rd_d;
  logic                 addr_ph;
  fpi_btn_st_t          bt_q;
  logic                 pressed;
  logic                 corrupt_lamp;

  // zero wait states; an unmapped address reads zero
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ph   = hsel && hready && htrans[1];

  always_comb begin
    rd_d = 32'h0;
    if (haddr[7:0] == FPI_CTRL_OFS) begin
      rd_d = {30'h0, ctrl_q};
    end else if (haddr[7:0] == FPI_BON_OFS) begin
      rd_d = {16'h0, bon_q};
    end else if (haddr[7:0] == FPI_BOFF_OFS) begin
      rd_d = {16'h0, boff_q};
    end else if (haddr[7:0] == FPI_BGAP_OFS) begin
      rd_d = {16'h0, bgap_q};
    end else if (haddr[7:0] == FPI_STAT_OFS) begin
      rd_d = {24'h0, bt_q, lamps};
    end else if (haddr[7:0] == FPI_ISTAT_OFS) begin
      rd_d = {28'h0, ist_q};
    end else if (haddr[7:0] == FPI_IEN_OFS) begin
      rd_d = {28'h0, ien_q};
    end
  end

  // address phase capture; read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wa_q      <= 8'h0;
      hrdata    <= 32'h0;
    end else begin
      wr_pend_q <= addr_ph && hwrite;
      if (addr_ph) begin
        wa_q <= haddr[7:0];
      end
      if (addr_ph && !hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  // writable registers, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= FPI_CTRL_RST;
      bon_q  <= FPI_BON_RST;
      boff_q <= FPI_BOFF_RST;
      bgap_q <= FPI_BGAP_RST;
      ien_q  <= '0;
    end else if (wr_pend_q) begin
      if (wa_q == FPI_CTRL_OFS) begin
        ctrl_q <= hwdata[1:0];
      end else if (wa_q == FPI_BON_OFS) begin
        bon_q <= hwdata[15:0];
      end else if (wa_q == FPI_BOFF_OFS) begin
        boff_q <= hwdata[15:0];
      end else if (wa_q == FPI_BGAP_OFS) begin
        bgap_q <= hwdata[15:0];
      end else if (wa_q == FPI_IEN_OFS) begin
        ien_q <= hwdata[FPI_NEV-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  assign clr = (wr_pend_q && wa_q == FPI_ICLR_OFS) ? hwdata[FPI_NEV-1:0] : '0;

  // a new event beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~clr) | ev;
    end
  end

  assign irq = |(ist_q & ien_q);

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick

  logic [31:0] tick_cnt_q;
  logic        tick;

  assign tick = (tick_cnt_q >= TICK_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset pushbutton

  logic [31:0] hold_q;

  fpi_debounce #(.CYC(DEB_CYC)) u_deb (
    .hclk    (hclk),
    .hresetn (hresetn),
    .raw     (!button_n),
    .clean   (pressed)
  );

  // press timing and reboot decision
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bt_q        <= FPI_BT_IDLE;
      hold_q      <= 32'h0;
      reboot_req  <= 1'b0;
      factory_req <= 1'b0;
    end else begin
      reboot_req  <= 1'b0;
      factory_req <= 1'b0;
      case (bt_q)
        FPI_BT_IDLE: begin
          hold_q <= 32'h0;
          if (pressed) begin
            bt_q <= FPI_BT_PRESS;
          end
        end
        FPI_BT_PRESS: begin
          if (!pressed) begin
            reboot_req <= 1'b1;
            bt_q       <= FPI_BT_IDLE;
          end else if (hold_q >= HOLD_CYC - 1) begin
            bt_q <= FPI_BT_LONG;
          end else begin
            hold_q <= hold_q + 32'h1;
          end
        end
        default: begin
          if (!pressed) begin
            reboot_req  <= 1'b1;
            factory_req <= 1'b1;
            bt_q        <= FPI_BT_IDLE;
          end
        end
      endcase
    end
  end

  // restored defaults are applied with the factory pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_default <= '0;
    end else if (bt_q == FPI_BT_LONG && !pressed) begin
      cfg_default.ip_dynamic    <= 1'b1;
      cfg_default.comment_empty <= 1'b1;
      cfg_default.admin_nopass  <= 1'b1;
      cfg_default.host_serial   <= serial_num;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events

  logic corrupt_q;
  logic link_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      corrupt_q <= 1'b0;
      link_q    <= 1'b0;
    end else begin
      corrupt_q <= fw_corrupt;
      link_q    <= phy.link_up;
    end
  end

  assign ev[FPI_EV_REBOOT]  = reboot_req;
  assign ev[FPI_EV_FACTORY] = factory_req;
  assign ev[FPI_EV_CORRUPT] = fw_corrupt && !corrupt_q;
  assign ev[FPI_EV_LINK]    = phy.link_up != link_q;

  ////////////////////////////////////////////////////////////////////////////
  // activity blink: a frame restarts a window in which the lamp flashes

  logic [15:0] act_ms_q;
  logic        act_ph_q;
  logic [15:0] act_win_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_ms_q  <= 16'h0;
      act_ph_q  <= 1'b0;
      act_win_q <= 16'h0;
    end else begin
      if (phy.activity) begin
        act_win_q <= 16'(2 * FPI_ACT_MS);
      end else if (tick && act_win_q != 16'h0) begin
        act_win_q <= act_win_q - 16'h1;
      end
      if (tick) begin
        if (act_ms_q >= 16'(FPI_ACT_MS - 1)) begin
          act_ms_q <= 16'h0;
          act_ph_q <= !act_ph_q;
        end else begin
          act_ms_q <= act_ms_q + 16'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lamps

  fpi_blink u_blink (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (fw_corrupt),
    .tick    (tick),
    .on_ms   (bon_q),
    .off_ms  (boff_q),
    .gap_ms  (bgap_q),
    .lamp    (corrupt_lamp)
  );

  fpi_lamps_t lamps_d;
  logic       act_show;

  // blinking drops the lamp only on the off phase
  assign act_show = ctrl_q[FPI_CTRL_ACTBL] && act_win_q != 16'h0 && act_ph_q;

  always_comb begin
    lamps_d.power  = power_ok;
    lamps_d.active = task_run;
    if (fw_corrupt) begin
      lamps_d.status = corrupt_lamp;
    end else begin
      lamps_d.status = fw_busy || bt_q == FPI_BT_LONG;
    end
    lamps_d.spd_yellow = phy.link_up && phy.speed == FPI_SPD_1000;
    lamps_d.spd_green  = phy.link_up && phy.speed == FPI_SPD_100;
    lamps_d.link_activity_lamp = phy.link_up && !act_show;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamps <= '0;
    end else begin
      lamps <= lamps_d;
    end
  end

  // auto crossover lets either cable type work at every speed
  assign mdix_auto = ctrl_q[FPI_CTRL_MDIX];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_POWER: assert property (power_ok |=> lamps.power)
    else $error("power lamp dark with power good");
  AST_ACTIVE: assert property (!task_run |=> !lamps.active)
    else $error("activity lamp lit with no task");
  AST_BUSY: assert property (fw_busy && !fw_corrupt |=> lamps.status)
    else $error("status lamp dark while firmware busy");
  AST_SPEED: assert property (phy.link_up && phy.speed == FPI_SPD_1000
    |=> lamps.spd_yellow && !lamps.spd_green)
    else $error("speed lamp not yellow at 1000");
  AST_SPEED_OFF: assert property (!phy.link_up || phy.speed == FPI_SPD_10
    |=> !lamps.spd_yellow && !lamps.spd_green)
    else $error("speed lamp lit with no fast link");
  AST_LINK: assert property (!phy.link_up |=> !lamps.link_activity_lamp)
    else $error("link lamp lit with no link");
  AST_SHORT: assert property (bt_q == FPI_BT_PRESS && !pressed
    |=> reboot_req && !factory_req ##1 !reboot_req)
    else $error("short press did not give one normal reboot");
  AST_HOLD: assert property (bt_q == FPI_BT_PRESS && pressed
    && hold_q == HOLD_CYC - 1 |=> bt_q == FPI_BT_LONG)
    else $error("long press not reached at hold count");
  AST_LONG_LAMP: assert property (bt_q == FPI_BT_LONG && !fw_corrupt
    |=> lamps.status)
    else $error("status lamp dark during long hold");
  AST_FACTORY: assert property (bt_q == FPI_BT_LONG && !pressed
    |=> factory_req && reboot_req && cfg_default.ip_dynamic ##1 ist_q[FPI_EV_FACTORY])
    else $error("long release did not restore defaults");
  AST_IRQ: assert property (ev[FPI_EV_REBOOT] && ien_q[FPI_EV_REBOOT]
    && !wr_pend_q |=> irq)
    else $error("enabled event did not raise interrupt");

  COV_SHORT: cover property (bt_q == FPI_BT_PRESS ##1 reboot_req && !factory_req);
  COV_LONG: cover property (factory_req);
  COV_BLINK: cover property (fw_corrupt && lamps.status ##1 !lamps.status);

endmodule : fpi_top

// >>> fpi_far_model.sv
// Purpose: far-side model of the pushbutton contact and the phy status
// Assumes: bench controls press, link, speed and traffic at rising edges
// Notes:   contact has no bounce; frames are one-cycle pulses every 8 cycles
`timescale 1ns/1ps
module fpi_far_model
  import fpi_pkg::*;
(
  input  wire logic       hclk,     // system clock
  input  wire logic       hresetn,  // async reset, active low
  input  wire logic       press,    // operator holds the button
  input  wire logic       link,     // link partner present
  input  wire logic [1:0] spd,      // negotiated speed code
  input  wire logic       traffic,  // frames flowing
  output logic            button_n, // contact, low when pressed
  output fpi_phy_t        phy       // phy status bundle
);
  logic [2:0] fcnt_q; // frame spacing
  //////////////////////////////////////////////////////////////////////////////
  // contact follows the finger; bounce is left to the bench's short taps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) button_n <= 1'b1;
    else button_n <= ~press;
  end
  // frames only while linked, so activity never shows without a link
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fcnt_q <= 3'h0;
      phy    <= '0;
    end else begin
      fcnt_q       <= fcnt_q + 3'h1;
      phy.link_up  <= link;
      phy.speed    <= spd;
      phy.activity <= link && traffic && (fcnt_q == 3'h0);
    end
  end
endmodule : fpi_far_model

// >>> fpi_top_tb_top.sv
// Purpose: self-checking bench for the front-panel lamps and reset button
// Assumes: short hold, debounce and tick counts to keep the run brief
// Notes:   checks are taken 1 ns after an edge so registered outputs settled
`timescale 1ns/1ps
module fpi_top_tb_top
  import fpi_pkg::*;
;
  localparam int unsigned HOLD = 200;
  localparam int unsigned DEB = 4;
  localparam int unsigned TICK = 4;
  localparam logic [31:0] SERIAL = 32'hC0DE0042; // arbitrary serial value
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        power_ok = 1'b0, task_run = 1'b0, fw_busy = 1'b0, fw_corrupt = 1'b0;
  logic        press = 1'b0, link = 1'b0, traffic = 1'b0;
  logic [1:0]  htrans = 2'h0, spd = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic        hreadyout, hresp, button_n, mdix_auto, reboot_req, factory_req, irq;
  fpi_phy_t    phy;
  fpi_lamps_t  lamps;
  fpi_cfg_t    cfg_default;
  int          err_count = 0, cmp_count = 0, reboots = 0, factories = 0;
  //////////////////////////////////////////////////////////////////////////////
  always #10 hclk = ~hclk;
  fpi_top #(.HOLD_CYC(HOLD), .DEB_CYC(DEB), .TICK_CYC(TICK)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .power_ok(power_ok),
    .task_run(task_run), .fw_busy(fw_busy), .fw_corrupt(fw_corrupt), .phy(phy),
    .button_n(button_n), .serial_num(SERIAL), .lamps(lamps), .mdix_auto(mdix_auto),
    .reboot_req(reboot_req), .factory_req(factory_req), .cfg_default(cfg_default),
    .irq(irq));
  fpi_far_model far_u (.hclk(hclk), .hresetn(hresetn), .press(press), .link(link),
    .spd(spd), .traffic(traffic), .button_n(button_n), .phy(phy));
  // pulses are one cycle wide, so count them rather than poll
  always @(posedge hclk) begin
    if (reboot_req === 1'b1) reboots++;
    if (factory_req === 1'b1) factories++;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : cyc
  // one single-word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0]  ofs [5] = '{FPI_CTRL_OFS, FPI_BON_OFS, FPI_BOFF_OFS, FPI_BGAP_OFS, 8'h20};
    logic [31:0] rst [5] = '{FPI_CTRL_RST, FPI_BON_RST, FPI_BOFF_RST, FPI_BGAP_RST, 0};
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ofs[i], 32'h0);
      check("reset value", rd, rst[i]);
    end
    check("mdix at reset", mdix_auto, 1'b1);
    check("bus answer", {hreadyout, hresp}, 2'b10);
    bus(1'b1, FPI_CTRL_OFS, 32'h2);
    cyc(2);
    check("mdix off", mdix_auto, 1'b0);
    bus(1'b1, FPI_CTRL_OFS, 32'h3);
  endtask : t_regs
  task automatic t_lamps;
    int lows;
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk);
      {fw_busy, task_run, power_ok} <= 3'(i);
      cyc(2);
      check("power lamp", lamps.power, power_ok);
      check("active lamp", lamps.active, task_run);
      check("status lamp", lamps.status, fw_busy);
    end
    for (int s = 0; s < 5; s++) begin
      @(posedge hclk);
      link <= (s < 4);
      fw_busy <= 1'b0;
      spd  <= (s < 4) ? 2'(s) : FPI_SPD_1000;
      cyc(4);
      check("speed lamps", {lamps.spd_yellow, lamps.spd_green},
            (s == 2) ? 2'b10 : (s == 1) ? 2'b01 : 2'b00);
      check("link lamp", lamps.link_activity_lamp, s < 4);
    end
    @(posedge hclk);
    link    <= 1'b1;
    traffic <= 1'b1;
    lows = 0;
    repeat (500) begin
      cyc(1);
      if (lamps.link_activity_lamp === 1'b0) lows++;
    end
    check("link lamp blinks", lows > 10 && lows < 450, 1'b1);
    @(posedge hclk);
    traffic <= 1'b0;
    cyc(500);
    check("link lamp steady", lamps.link_activity_lamp, 1'b1);
  endtask : t_lamps
  task automatic t_short;
    int r0;
    bus(1'b1, FPI_ICLR_OFS, 32'hF);
    bus(1'b1, FPI_IEN_OFS, 32'h1);
    r0 = reboots;
    @(posedge hclk);
    press <= 1'b1;
    repeat (2) @(posedge hclk);
    press <= 1'b0;
    cyc(40);
    check("tap ignored", reboots - r0, 0);
    @(posedge hclk);
    press <= 1'b1;
    repeat (60) @(posedge hclk);
    press <= 1'b0;
    cyc(20);
    check("short reboots", reboots - r0, 1);
    check("short no factory", factories, 0);
    check("irq raised", irq, 1'b1);
    bus(1'b0, FPI_ISTAT_OFS, 32'h0);
    check("istat", rd[1:0], 2'b01);
    bus(1'b1, FPI_IEN_OFS, 32'h0);
    cyc(2);
    check("irq masked", irq, 1'b0);
    bus(1'b1, FPI_IEN_OFS, 32'h1);
    bus(1'b1, FPI_ICLR_OFS, 32'h1);
    cyc(2);
    check("irq cleared", irq, 1'b0);
  endtask : t_short
  task automatic t_long;
    @(posedge hclk);
    press <= 1'b1;
    cyc(HOLD / 2);
    check("status before hold", lamps.status, 1'b0);
    cyc(HOLD);
    check("status on hold", lamps.status, 1'b1);
    bus(1'b0, FPI_STAT_OFS, 32'h0);
    check("button state", rd[7:6], 2'h2);
    @(posedge hclk);
    press <= 1'b0;
    cyc(20);
    check("factory pulse", factories, 1);
    check("reboot pulse", reboots, 2);
    check("defaults", cfg_default, {3'b111, SERIAL});
    check("status after", lamps.status, 1'b0);
  endtask : t_long
  task automatic t_corrupt;
    int n, rises;
    logic prev;
    bus(1'b1, FPI_BON_OFS, 32'h2);
    bus(1'b1, FPI_BOFF_OFS, 32'h3);
    bus(1'b1, FPI_BGAP_OFS, 32'h5);
    @(posedge hclk);
    fw_corrupt <= 1'b1;
    n = 0;
    while (lamps.status !== 1'b1 && n++ < 300) cyc(1);
    check("corrupt lamp lit", lamps.status, 1'b1);
    // three periods of 17 ms at 4 cycles a ms, first rise excluded
    prev = 1'b1;
    rises = 0;
    repeat (200) begin
      cyc(1);
      if (lamps.status === 1'b1 && prev !== 1'b1) rises++;
      prev = lamps.status;
    end
    check("blink rises", rises, 8);
    bus(1'b0, FPI_ISTAT_OFS, 32'h0);
    check("corrupt event", rd[2], 1'b1);
    @(posedge hclk);
    fw_corrupt <= 1'b0;
  endtask : t_corrupt
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // all scenarios together need under two thousand cycles
  initial begin
    cyc(20000);
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    t_regs;
    t_lamps;
    t_short;
    t_long;
    t_corrupt;
    tally_and_finish;
  end
endmodule : fpi_top_tb_top
